// >>> design/rrl_pkg.sv
package rrl_pkg;

	// ----------------------------------------------------------------
	// Reset type codes
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_HW_NOW = 8'h00;
	localparam logic [7:0] RST_SW = 8'h01;
	localparam logic [7:0] RST_NAV = 8'h02;
	localparam logic [7:0] RST_HW_SHUT = 8'h04;
	localparam logic [7:0] RST_NAV_STOP = 8'h08;
	localparam logic [7:0] RST_NAV_START = 8'h09;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_RESET_REQ = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_CFG = 8'h08;
	localparam logic [7:0] OFS_INT_STAT = 8'h0C;
	localparam logic [7:0] OFS_INT_MASK = 8'h10;
	localparam logic [7:0] OFS_LOG_IDX = 8'h14;
	localparam logic [7:0] OFS_LOG_DATA = 8'h18;
	localparam logic [7:0] OFS_FW_ERASE = 8'h1C;
	localparam logic [7:0] OFS_RUNTIME = 8'h20;
	localparam logic [7:0] OFS_EPH = 8'h24;

	// ----------------------------------------------------------------
	// Field positions and codes
	// ----------------------------------------------------------------
	localparam int CMD_MASK_LSB = 8;
	localparam int CFG_LOCK_BIT = 8;
	localparam int CFG_LAYER_LSB = 9;
	localparam logic [1:0] LAYER_RAM = 2'h0;
	localparam logic [1:0] LAYER_BAT = 2'h1;
	localparam logic [1:0] LAYER_FLASH = 2'h2;
	localparam logic [1:0] EVT_STARTED = 2'h0;
	localparam logic [1:0] EVT_STOPPED = 2'h1;
	localparam logic [1:0] EVT_TRIGGERED = 2'h2;
	localparam logic [1:0] EVT_TIMEOUT = 2'h3;
	localparam logic [1:0] START_HOT = 2'h0;
	localparam logic [1:0] START_WARM = 2'h1;
	localparam logic [1:0] START_COLD = 2'h2;
	localparam logic [15:0] MASK_ALL = 16'hFFFF;
	localparam int INT_DONE = 0;
	localparam int INT_REJECT = 1;
	localparam int INT_LOG_WRAP = 2;
	localparam int INT_PIN = 3;
	localparam int INT_W = 4;

	// ----------------------------------------------------------------
	// Timing and sizes
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 40_000_000;
	localparam int PIN_LOW_MIN_US = 1000;
	localparam int PIN_LOW_CYCLES = (PIN_LOW_MIN_US * (CLK_HZ / 1_000_000));
	localparam int SEC_CYCLES = CLK_HZ;
	localparam int EPH_VALID_HOURS = 4;
	localparam int EPH_VALID_SECS = EPH_VALID_HOURS * 3600;
	localparam logic [3:0] WDOG_LAST = 4'hF;
	localparam logic [4:0] LOG_DEPTH = 5'h10;
	localparam logic [1:0] PIN_SYNC_RESET = 2'h3;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_STOP = 5'b00010,
		ST_SHUT = 5'b00100,
		ST_WDOG = 5'b01000,
		ST_BOOT = 5'b10000
	} rrl_state_t;

	typedef struct packed {
		logic [1:0] det;
		logic [1:0] evt;
	} rrl_log_entry_t;

	typedef struct packed {
		logic valid;
		logic entry_valid;
		rrl_log_entry_t entry;
	} rrl_sec_evt_t;

	typedef struct packed {
		logic valid;
		logic config_lock_flag;
		logic [7:0] value;
	} rrl_layer_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} rrl_bus_req_t;

	localparam rrl_layer_t LAYER_EMPTY = 10'h000;

endpackage

// >>> design/rrl_reset_retention_lock_ctrl.sv
// Function
// - Code 0x00: immediate watchdog reset, no stops.
// - Code 0x04: shutdown first, then watchdog reset.
// - Hardware resets clear RAM and battery RAM.
// - Code 0x01: orderly stop, restart, reload, clear RAM.
// - Code 0x02: restart navigation only, clear nothing.
// - Codes 0x08/0x09 stop/start navigation, clear nothing.
// - Request carries start-mode clear mask.
// - Stale orbit data beyond window gives warm start.
// - Long low reset pin clears both RAMs, cold.
// - Log holds sixteen, newest overwrites oldest.
// - Entry holds detection type and event type.
// - Restart or power cycle empties the log.
// - Startup merges layers into run-time configuration.
// - Run-time lock rejects every configuration change.
// - Volatile lock vanishes when its memory clears.
// - Flash lock survives resets, only firmware erase.
// - Polls and other messages accepted while locked.
//
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module rrl_reset_retention_lock_ctrl #(
	parameter int PIN_LOW_CYCLES = rrl_pkg::PIN_LOW_CYCLES,
	parameter int SEC_CYCLES = rrl_pkg::SEC_CYCLES,
	parameter int EPH_VALID_SECS = rrl_pkg::EPH_VALID_SECS
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// Register port
	input wire rrl_pkg::rrl_bus_req_t bus_req,
	output logic [31:0] rd_data,
	// External reset pin, active low
	input wire logic reset_n_pin,
	// Chip handshakes
	input wire logic procs_idle,
	input wire logic shutdown_done,
	input wire rrl_pkg::rrl_sec_evt_t sec_evt,
	// Restart controls
	output logic chip_reset,
	output logic clear_ram,
	output logic clear_battery_backed_ram,
	output logic proc_stop_req,
	output logic shutdown_req,
	output logic cfg_reload,
	output logic nav_run,
	output logic nav_restart,
	output logic [1:0] start_mode,
	output logic [15:0] start_mode_clear_mask,
	// Interrupt
	output logic irq
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic code_ok(input logic [7:0] c);
		code_ok = (c == rrl_pkg::RST_HW_NOW) || (c == rrl_pkg::RST_SW) ||
			(c == rrl_pkg::RST_NAV) || (c == rrl_pkg::RST_HW_SHUT) ||
			(c == rrl_pkg::RST_NAV_STOP) || (c == rrl_pkg::RST_NAV_START);
	endfunction

	// Highest-priority valid layer supplies the value; a lock on any layer locks.
	function automatic rrl_pkg::rrl_layer_t merge(input rrl_pkg::rrl_layer_t r,
			input rrl_pkg::rrl_layer_t b, input rrl_pkg::rrl_layer_t f);
		rrl_pkg::rrl_layer_t m;
		m = r.valid ? r : (b.valid ? b : f);
		m.config_lock_flag = (r.valid & r.config_lock_flag) |
			(b.valid & b.config_lock_flag) | (f.valid & f.config_lock_flag);
		merge = m;
	endfunction

	// ----------------------------------------------------------------
	// Registers and decode
	// ----------------------------------------------------------------
	rrl_pkg::rrl_state_t state_reg, state_next;
	logic [3:0] wdog_reg, wdog_next;
	logic [1:0] pin_sync_reg;
	logic [15:0] pin_cnt_reg;
	logic [25:0] sec_cnt_reg;
	logic [15:0] age_reg, age_next;
	logic clr_ram_now, clr_bat_now, nav_run_next, nav_restart_next;
	logic cold_pend_reg, cfg_reload_reg, nav_run_reg, nav_restart_reg;
	logic chip_reset_reg, clear_ram_reg, clear_bat_reg, stop_reg, shut_reg;
	logic [1:0] start_mode_reg;
	logic [15:0] mask_reg;
	rrl_pkg::rrl_layer_t layer_ram_reg, layer_bat_reg, layer_flash_reg, runtime_reg;
	rrl_pkg::rrl_layer_t ram_next, bat_next, flash_next, runtime_next;
	logic [rrl_pkg::INT_W-1:0] int_reg, int_mask_reg, int_ev;
	logic [3:0] log_idx_reg, log_wp_reg;
	logic [4:0] log_cnt_reg;
	rrl_pkg::rrl_log_entry_t log_mem [16];
	logic [31:0] rd_word;

	wire wr_hit = bus_req.wr;
	wire [7:0] cmd_type = bus_req.wdata[7:0];
	wire [15:0] cmd_mask = bus_req.wdata[rrl_pkg::CMD_MASK_LSB +: 16];
	wire pin_low = !pin_sync_reg[1];
	wire pin_fire = pin_low && (pin_cnt_reg == 16'(PIN_LOW_CYCLES - 1));
	wire cmd_take = wr_hit && (bus_req.addr == rrl_pkg::OFS_RESET_REQ) &&
		(state_reg == rrl_pkg::ST_IDLE) && !pin_fire;
	wire cfg_wr = wr_hit && (bus_req.addr == rrl_pkg::OFS_CFG);
	wire cfg_rej = cfg_wr && runtime_reg.config_lock_flag;
	wire cfg_ok = cfg_wr && !runtime_reg.config_lock_flag;
	wire [1:0] cfg_sel = bus_req.wdata[rrl_pkg::CFG_LAYER_LSB +: 2];
	wire fw_erase = wr_hit && (bus_req.addr == rrl_pkg::OFS_FW_ERASE) && bus_req.wdata[0];
	wire eph_fresh = wr_hit && (bus_req.addr == rrl_pkg::OFS_EPH);
	wire int_w1c = wr_hit && (bus_req.addr == rrl_pkg::OFS_INT_STAT);
	wire sec_tick = (sec_cnt_reg == 26'(SEC_CYCLES - 1));
	wire stale = (age_reg > 16'(EPH_VALID_SECS));
	wire in_boot = (state_reg == rrl_pkg::ST_BOOT);
	wire log_full = (log_cnt_reg == rrl_pkg::LOG_DEPTH);
	wire log_evt = sec_evt.valid && !in_boot;
	wire [3:0] log_pos = (log_full ? log_wp_reg : 4'h0) + log_idx_reg;
	wire log_idx_ok = ({1'b0, log_idx_reg} < log_cnt_reg);
	wire flash_wr = cfg_ok && (cfg_sel == rrl_pkg::LAYER_FLASH);
	wire rrl_pkg::rrl_layer_t cfg_new = {1'b1, bus_req.wdata[rrl_pkg::CFG_LOCK_BIT],
		bus_req.wdata[7:0]};

	// ----------------------------------------------------------------
	// Reset pin: synchroniser and low-time filter
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			pin_sync_reg <= rrl_pkg::PIN_SYNC_RESET;
			pin_cnt_reg <= 16'h0000;
		end else begin
			pin_sync_reg <= {pin_sync_reg[0], reset_n_pin};
			// The counter parks one past the firing count so one long low fires once.
			if (!pin_low)
				pin_cnt_reg <= 16'h0000;
			else if (pin_cnt_reg != 16'(PIN_LOW_CYCLES))
				pin_cnt_reg <= pin_cnt_reg + 16'h0001;
			else
				pin_cnt_reg <= pin_cnt_reg;
		end
	end

	// ----------------------------------------------------------------
	// Restart sequencer
	// ----------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		wdog_next = wdog_reg;
		clr_ram_now = 1'b0;
		clr_bat_now = 1'b0;
		nav_run_next = nav_run_reg;
		nav_restart_next = 1'b0;
		if (pin_fire) begin
			state_next = rrl_pkg::ST_WDOG;
			clr_ram_now = 1'b1;
			clr_bat_now = 1'b1;
			wdog_next = 4'h0;
		end else begin
			unique case (state_reg)
				rrl_pkg::ST_IDLE: begin
					if (cmd_take) begin
						case (cmd_type)
							rrl_pkg::RST_HW_NOW: begin
								state_next = rrl_pkg::ST_WDOG;
								clr_ram_now = 1'b1;
								clr_bat_now = 1'b1;
								wdog_next = 4'h0;
							end
							rrl_pkg::RST_HW_SHUT: state_next = rrl_pkg::ST_SHUT;
							rrl_pkg::RST_SW: state_next = rrl_pkg::ST_STOP;
							rrl_pkg::RST_NAV: nav_restart_next = 1'b1;
							rrl_pkg::RST_NAV_STOP: nav_run_next = 1'b0;
							rrl_pkg::RST_NAV_START: nav_run_next = 1'b1;
							default: state_next = rrl_pkg::ST_IDLE;
						endcase
					end
				end
				rrl_pkg::ST_STOP: begin
					nav_run_next = 1'b0;
					if (procs_idle) begin
						state_next = rrl_pkg::ST_BOOT;
						clr_ram_now = 1'b1;
					end
				end
				rrl_pkg::ST_SHUT: begin
					nav_run_next = 1'b0;
					if (shutdown_done) begin
						state_next = rrl_pkg::ST_WDOG;
						clr_ram_now = 1'b1;
						clr_bat_now = 1'b1;
						wdog_next = 4'h0;
					end
				end
				rrl_pkg::ST_WDOG: begin
					nav_run_next = 1'b0;
					if (wdog_reg == rrl_pkg::WDOG_LAST)
						state_next = rrl_pkg::ST_BOOT;
					else
						wdog_next = wdog_reg + 4'h1;
				end
				rrl_pkg::ST_BOOT: begin
					state_next = rrl_pkg::ST_IDLE;
					nav_run_next = 1'b1;
				end
				default: state_next = rrl_pkg::ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			state_reg <= rrl_pkg::ST_BOOT;
			wdog_reg <= 4'h0;
			nav_run_reg <= 1'b0;
			nav_restart_reg <= 1'b0;
			chip_reset_reg <= 1'b0;
			clear_ram_reg <= 1'b0;
			clear_bat_reg <= 1'b0;
			stop_reg <= 1'b0;
			shut_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			wdog_reg <= wdog_next;
			nav_run_reg <= nav_run_next;
			nav_restart_reg <= nav_restart_next;
			chip_reset_reg <= (state_next == rrl_pkg::ST_WDOG);
			clear_ram_reg <= clr_ram_now;
			clear_bat_reg <= clr_bat_now;
			stop_reg <= (state_next == rrl_pkg::ST_STOP);
			shut_reg <= (state_next == rrl_pkg::ST_SHUT);
		end
	end

	// ----------------------------------------------------------------
	// Start mode and orbit-data age
	// ----------------------------------------------------------------
	// Age counts whole seconds; losing battery RAM makes orbit data stale at once.
	always_comb begin
		age_next = age_reg;
		if (clr_bat_now)
			age_next = 16'(EPH_VALID_SECS + 1);
		else if (eph_fresh)
			age_next = 16'h0000;
		else if (sec_tick && !stale)
			age_next = age_reg + 16'h0001;
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			sec_cnt_reg <= 26'h0000000;
			age_reg <= 16'(EPH_VALID_SECS + 1);
			cold_pend_reg <= 1'b1;
			mask_reg <= rrl_pkg::MASK_ALL;
			start_mode_reg <= rrl_pkg::START_COLD;
			cfg_reload_reg <= 1'b0;
		end else begin
			sec_cnt_reg <= sec_tick ? 26'h0000000 : sec_cnt_reg + 26'h0000001;
			age_reg <= age_next;
			cold_pend_reg <= clr_bat_now | (cold_pend_reg & !in_boot);
			if (cmd_take && code_ok(cmd_type))
				mask_reg <= cmd_mask;
			if (in_boot) begin
				if (cold_pend_reg || mask_reg == rrl_pkg::MASK_ALL)
					start_mode_reg <= rrl_pkg::START_COLD;
				else if (stale || mask_reg != 16'h0000)
					start_mode_reg <= rrl_pkg::START_WARM;
				else
					start_mode_reg <= rrl_pkg::START_HOT;
			end
			cfg_reload_reg <= in_boot;
		end
	end

	// ----------------------------------------------------------------
	// Configuration layers and lock
	// ----------------------------------------------------------------
	assign ram_next = clr_ram_now ? rrl_pkg::LAYER_EMPTY :
		((cfg_ok && cfg_sel == rrl_pkg::LAYER_RAM) ? cfg_new : layer_ram_reg);
	assign bat_next = clr_bat_now ? rrl_pkg::LAYER_EMPTY :
		((cfg_ok && cfg_sel == rrl_pkg::LAYER_BAT) ? cfg_new : layer_bat_reg);
	assign flash_next = fw_erase ? rrl_pkg::LAYER_EMPTY :
		(flash_wr ? cfg_new : layer_flash_reg);
	// The run-time copy lives in working RAM, so clearing it drops any lock.
	assign runtime_next = clr_ram_now ? rrl_pkg::LAYER_EMPTY :
		(in_boot ? merge(layer_ram_reg, layer_bat_reg, layer_flash_reg) :
		((cfg_ok && cfg_sel == rrl_pkg::LAYER_RAM) ?
		merge(cfg_new, layer_bat_reg, layer_flash_reg) : runtime_reg));

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			layer_ram_reg <= rrl_pkg::LAYER_EMPTY;
			layer_bat_reg <= rrl_pkg::LAYER_EMPTY;
			layer_flash_reg <= rrl_pkg::LAYER_EMPTY;
			runtime_reg <= rrl_pkg::LAYER_EMPTY;
		end else begin
			layer_ram_reg <= ram_next;
			layer_bat_reg <= bat_next;
			layer_flash_reg <= flash_next;
			runtime_reg <= runtime_next;
		end
	end

	// ----------------------------------------------------------------
	// Security event log
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (log_evt)
			log_mem[log_wp_reg] <= sec_evt.entry;
	end

	always_ff @(posedge ref_clk) begin
		if (reset || in_boot) begin
			log_wp_reg <= 4'h0;
			log_cnt_reg <= 5'h00;
		end else if (log_evt) begin
			log_wp_reg <= log_wp_reg + 4'h1;
			log_cnt_reg <= log_full ? log_cnt_reg : log_cnt_reg + 5'h01;
		end
	end

	// ----------------------------------------------------------------
	// Interrupts and register port
	// ----------------------------------------------------------------
	assign int_ev = {pin_fire, log_evt && log_full, cfg_rej, in_boot};
	assign irq = |(int_reg & int_mask_reg);

	always_comb begin
		rd_word = 32'h00000000;
		case (bus_req.addr)
			rrl_pkg::OFS_RESET_REQ: rd_word = {16'h0000, mask_reg};
			rrl_pkg::OFS_STATUS: rd_word = {16'h0000, layer_flash_reg.config_lock_flag,
				log_cnt_reg, start_mode_reg, nav_run_reg, stale,
				runtime_reg.config_lock_flag, state_reg};
			rrl_pkg::OFS_CFG: rd_word = {22'h000000, runtime_reg};
			rrl_pkg::OFS_INT_STAT: rd_word = {28'h0000000, int_reg};
			rrl_pkg::OFS_INT_MASK: rd_word = {28'h0000000, int_mask_reg};
			rrl_pkg::OFS_LOG_IDX: rd_word = {28'h0000000, log_idx_reg};
			rrl_pkg::OFS_LOG_DATA: rd_word = {11'h000, log_cnt_reg, 11'h000, log_idx_ok,
				log_idx_ok ? log_mem[log_pos] : 4'h0};
			rrl_pkg::OFS_RUNTIME: rd_word = {22'h000000, runtime_reg};
			rrl_pkg::OFS_EPH: rd_word = {16'h0000, age_reg};
			default: rd_word = 32'h00000000;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			int_reg <= 4'h0;
			int_mask_reg <= 4'h0;
			log_idx_reg <= 4'h0;
			rd_data <= 32'h00000000;
		end else begin
			// A new event wins over a write-one-to-clear in the same cycle.
			int_reg <= (int_reg & ~(int_w1c ? bus_req.wdata[3:0] : 4'h0)) | int_ev;
			if (wr_hit && bus_req.addr == rrl_pkg::OFS_INT_MASK)
				int_mask_reg <= bus_req.wdata[3:0];
			if (wr_hit && bus_req.addr == rrl_pkg::OFS_LOG_IDX)
				log_idx_reg <= bus_req.wdata[3:0];
			rd_data <= bus_req.rd ? rd_word : 32'h00000000;
		end
	end

	assign chip_reset = chip_reset_reg;
	assign clear_ram = clear_ram_reg;
	assign clear_battery_backed_ram = clear_bat_reg;
	assign proc_stop_req = stop_reg;
	assign shutdown_req = shut_reg;
	assign cfg_reload = cfg_reload_reg;
	assign nav_run = nav_run_reg;
	assign nav_restart = nav_restart_reg;
	assign start_mode = start_mode_reg;
	assign start_mode_clear_mask = mask_reg;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	sequence s_cmd(logic [7:0] c);
		cmd_take && cmd_type == c;
	endsequence
	sequence s_sw_idle;
		state_reg == rrl_pkg::ST_STOP && procs_idle && !pin_fire;
	endsequence

	property p_hw_now;
		s_cmd(rrl_pkg::RST_HW_NOW) |=> chip_reset && clear_ram && clear_battery_backed_ram &&
			!proc_stop_req && !shutdown_req ##16 state_reg == rrl_pkg::ST_BOOT;
	endproperty
	a_hw_now: assert property (p_hw_now) else $error("immediate reset wrong");
	property p_hw_shut;
		s_cmd(rrl_pkg::RST_HW_SHUT) |=> shutdown_req && !chip_reset && !clear_ram;
	endproperty
	a_hw_shut: assert property (p_hw_shut) else $error("shutdown not first");
	property p_hw_mem;
		(state_reg == rrl_pkg::ST_SHUT && shutdown_done && !pin_fire) |=>
			chip_reset && clear_ram && clear_battery_backed_ram && $stable(layer_flash_reg);
	endproperty
	a_hw_mem: assert property (p_hw_mem) else $error("hardware clear wrong");
	property p_sw;
		s_sw_idle |=> clear_ram && !clear_battery_backed_ram ##1
			cfg_reload && state_reg == rrl_pkg::ST_IDLE;
	endproperty
	a_sw: assert property (p_sw) else $error("software reset wrong");
	property p_nav;
		s_cmd(rrl_pkg::RST_NAV) |=> nav_restart && !clear_ram &&
			!clear_battery_backed_ram && !cfg_reload;
	endproperty
	a_nav: assert property (p_nav) else $error("navigation restart wrong");
	property p_nav_stop;
		s_cmd(rrl_pkg::RST_NAV_STOP) |=> !nav_run && !clear_ram && state_reg == rrl_pkg::ST_IDLE;
	endproperty
	a_nav_stop: assert property (p_nav_stop) else $error("navigation stop wrong");
	property p_pin;
		pin_fire |=> clear_ram && clear_battery_backed_ram ##17 start_mode == rrl_pkg::START_COLD;
	endproperty
	a_pin: assert property (p_pin) else $error("pin reset not cold");
	property p_log_wrap;
		log_evt && log_full |=> log_cnt_reg == rrl_pkg::LOG_DEPTH && int_reg[rrl_pkg::INT_LOG_WRAP];
	endproperty
	a_log_wrap: assert property (p_log_wrap) else $error("log overflow wrong");
	property p_log_clear;
		in_boot |=> log_cnt_reg == 5'h00;
	endproperty
	a_log_clear: assert property (p_log_clear) else $error("log not emptied");
	property p_lock;
		cfg_rej && !clr_ram_now && !clr_bat_now && !fw_erase |=> int_reg[rrl_pkg::INT_REJECT] &&
			$stable(layer_ram_reg) && $stable(layer_bat_reg) && $stable(layer_flash_reg);
	endproperty
	a_lock: assert property (p_lock) else $error("locked change accepted");
	property p_vol_lock;
		clr_ram_now |=> !runtime_reg.config_lock_flag;
	endproperty
	a_vol_lock: assert property (p_vol_lock) else $error("volatile lock kept");
	property p_flash;
		!fw_erase && !flash_wr |=> $stable(layer_flash_reg);
	endproperty
	a_flash: assert property (p_flash) else $error("flash layer changed");
	property p_bad;
		cmd_take && !code_ok(cmd_type) |=> state_reg == rrl_pkg::ST_IDLE && !clear_ram &&
			!clear_battery_backed_ram && $stable(mask_reg);
	endproperty
	a_bad: assert property (p_bad) else $error("unknown code acted on");

endmodule
`default_nettype wire

// >>> sim/rrl_chip_model.sv
`timescale 1ns/1ps
`default_nettype none
module rrl_chip_model (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// Requests from the controller, and the slow setting from the testbench
	input wire logic proc_stop_req,
	input wire logic shutdown_req,
	input wire logic slow,
	// Answers
	output logic procs_idle,
	output logic shutdown_done
);
	// ----------------------------------------------------------------
	// Wind-down timer
	// ----------------------------------------------------------------
	// The slow setting stretches the wind-down so a stall is exercised.
	logic [3:0] wait_reg;
	always_ff @(posedge ref_clk) begin
		if (reset || !(proc_stop_req || shutdown_req)) begin
			wait_reg <= 4'h0;
		end else if (wait_reg != 4'hF) begin
			wait_reg <= wait_reg + 4'h1;
		end
	end
	assign procs_idle = proc_stop_req && (wait_reg >= (slow ? 4'hC : 4'h1));
	assign shutdown_done = shutdown_req && (wait_reg >= (slow ? 4'hC : 4'h1));
endmodule
`default_nettype wire

// >>> sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic ref_clk, reset, reset_n_pin, procs_idle, shutdown_done, slow, irq;
	logic chip_reset, clear_ram, clear_battery_backed_ram, proc_stop_req, shutdown_req;
	logic cfg_reload, nav_run, nav_restart;
	logic [1:0] start_mode;
	logic [15:0] start_mode_clear_mask;
	logic [31:0] rd_data, v;
	rrl_pkg::rrl_bus_req_t bus_req;
	rrl_pkg::rrl_sec_evt_t sec_evt;
	int n_mismatch = 0, n_compared = 0, cycles = 0, n;

	rrl_reset_retention_lock_ctrl #(.PIN_LOW_CYCLES(20), .SEC_CYCLES(4), .EPH_VALID_SECS(3))
		i_rrl_reset_retention_lock_ctrl (.ref_clk(ref_clk), .reset(reset), .bus_req(bus_req),
		.rd_data(rd_data), .reset_n_pin(reset_n_pin), .procs_idle(procs_idle),
		.shutdown_done(shutdown_done), .sec_evt(sec_evt), .chip_reset(chip_reset),
		.clear_ram(clear_ram), .clear_battery_backed_ram(clear_battery_backed_ram),
		.proc_stop_req(proc_stop_req), .shutdown_req(shutdown_req), .cfg_reload(cfg_reload),
		.nav_run(nav_run), .nav_restart(nav_restart), .start_mode(start_mode),
		.start_mode_clear_mask(start_mode_clear_mask), .irq(irq));
	rrl_chip_model i_rrl_chip_model (.ref_clk(ref_clk), .reset(reset),
		.proc_stop_req(proc_stop_req), .shutdown_req(shutdown_req), .slow(slow),
		.procs_idle(procs_idle), .shutdown_done(shutdown_done));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task cyc;
		@(posedge ref_clk);
		#1;
	endtask
	task chk(input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			n_mismatch++;
			$display("ERROR %0t: got %h want %h", $time, s, e);
		end
	endtask
	// A leading idle cycle keeps two strobes from landing in one time step.
	task wr(input logic [7:0] a, input logic [31:0] d);
		cyc;
		bus_req <= {a, d, 2'b10};
		cyc;
		bus_req <= '0;
	endtask
	task rd(input logic [7:0] a);
		cyc;
		bus_req <= {a, 32'h0, 2'b01};
		cyc;
		bus_req <= '0;
		v = rd_data;
	endtask
	task wait_boot;
		for (n = 0; n < 300 && cfg_reload !== 1'b1; n++) cyc;
		chk(32'(cfg_reload), 32'h1);
	endtask
	task stop_test;
		$display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	initial begin
		ref_clk = 0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			stop_test;
		end
	end

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial begin
		reset = 1;
		reset_n_pin = 1;
		slow = 0;
		bus_req = '0;
		sec_evt = '0;
		repeat (2) @(posedge ref_clk);
		reset <= 0;
		wait_boot;
		chk(32'(start_mode), 32'h2);
		wr(rrl_pkg::OFS_INT_MASK, 32'hF);
		chk(32'(irq), 32'h1);
		wr(rrl_pkg::OFS_INT_STAT, 32'hF);
		chk(32'(irq), 32'h0);
		wr(rrl_pkg::OFS_INT_MASK, 32'h4);
		wr(rrl_pkg::OFS_RESET_REQ, 32'h0000_1203);
		chk(32'({clear_ram, proc_stop_req, chip_reset}), 32'h0);
		rd(rrl_pkg::OFS_RESET_REQ);
		chk(v, 32'h0000_FFFF);
		wr(rrl_pkg::OFS_EPH, 32'h0);
		wr(rrl_pkg::OFS_RESET_REQ, 32'h1);
		chk(32'({proc_stop_req, clear_battery_backed_ram}), 32'h2);
		wait_boot;
		chk(32'(start_mode), 32'h0);
		chk(32'(start_mode_clear_mask), 32'h0);
		repeat (40) cyc;
		wr(rrl_pkg::OFS_RESET_REQ, 32'h1);
		wait_boot;
		chk(32'(start_mode), 32'h1);
		wr(rrl_pkg::OFS_CFG, 32'h155);
		rd(rrl_pkg::OFS_RUNTIME);
		chk(v, 32'h355);
		wr(rrl_pkg::OFS_CFG, 32'h0AA);
		rd(rrl_pkg::OFS_RUNTIME);
		chk(v, 32'h355);
		rd(rrl_pkg::OFS_INT_STAT);
		chk(v, 32'h3);
		wr(rrl_pkg::OFS_RESET_REQ, 32'h1);
		wait_boot;
		rd(rrl_pkg::OFS_RUNTIME);
		chk(v & 32'h100, 32'h0);
		for (int i = 0; i < 17; i++) begin
			sec_evt <= {2'b10, 4'(i)};
			cyc;
			sec_evt <= '0;
			cyc;
		end
		chk(32'(irq), 32'h1);
		wr(rrl_pkg::OFS_INT_STAT, 32'h4);
		chk(32'(irq), 32'h0);
		wr(rrl_pkg::OFS_LOG_IDX, 32'h0);
		rd(rrl_pkg::OFS_LOG_DATA);
		chk(v, 32'h0010_0011);
		wr(rrl_pkg::OFS_RESET_REQ, 32'h2);
		chk(32'({nav_restart, clear_ram, clear_battery_backed_ram}), 32'h4);
		wr(rrl_pkg::OFS_RESET_REQ, 32'h8);
		chk(32'({nav_run, clear_ram}), 32'h0);
		wr(rrl_pkg::OFS_RESET_REQ, 32'h9);
		chk(32'({nav_run, clear_ram}), 32'h2);
		wr(rrl_pkg::OFS_RESET_REQ, 32'h1);
		wait_boot;
		rd(rrl_pkg::OFS_LOG_DATA);
		chk(v & 32'h001F_0010, 32'h0);
		slow = 1;
		wr(rrl_pkg::OFS_RESET_REQ, 32'h00FF_FF04);
		chk(32'({shutdown_req, clear_ram, chip_reset}), 32'h4);
		for (n = 0; n < 100 && clear_ram !== 1'b1; n++) cyc;
		chk(32'({chip_reset, clear_battery_backed_ram, n > 8}), 32'h7);
		wait_boot;
		wr(rrl_pkg::OFS_CFG, 32'h512);
		wr(rrl_pkg::OFS_RESET_REQ, 32'h0);
		chk(32'({chip_reset, clear_ram, clear_battery_backed_ram, proc_stop_req}), 32'hE);
		wait_boot;
		rd(rrl_pkg::OFS_STATUS);
		chk(v & 32'h8020, 32'h8020);
		wr(rrl_pkg::OFS_CFG, 32'h1AA);
		rd(rrl_pkg::OFS_RUNTIME);
		chk(v & 32'h3FF, 32'h312);
		wr(rrl_pkg::OFS_FW_ERASE, 32'h1);
		rd(rrl_pkg::OFS_STATUS);
		chk(v & 32'h8000, 32'h0);
		reset_n_pin <= 0;
		for (n = 0; n < 100 && clear_battery_backed_ram !== 1'b1; n++) cyc;
		chk(32'({clear_ram, clear_battery_backed_ram, n >= 20}), 32'h7);
		repeat (5) cyc;
		chk(32'(clear_battery_backed_ram), 32'h0);
		reset_n_pin <= 1;
		wait_boot;
		chk(32'(start_mode), 32'h2);
		stop_test;
	end
endmodule
`default_nettype wire
